// [bench/timer2_capture_reload_control_tb_top.sv]
`timescale 1ns/100ps
module timer2_capture_reload_control_tb_top;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, count_pin = 1'h0;
  logic [1:0] serial_mode = 2'h0, s_axi_bresp, s_axi_rresp, rrsp;
  logic timer2_int_enable = 1'h0, t1_on = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic trigger_pin, timer1_overflow, rx_baud_clock, tx_baud_clock;
  logic timer2_int_request, irq;
  int num_errors = 0, samples_checked = 0, n0, m0;
  tmr2_control u_dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_pin,
    .count_pin, .timer1_overflow, .timer2_int_enable, .serial_mode, .rx_baud_clock,
    .tx_baud_clock, .timer2_int_request, .irq);
  tmr2_peer u_peer (.clk, .t1_on, .rx_baud_clock, .tx_baud_clock, .trigger_pin,
    .timer1_overflow);
  initial forever #20 clk = ~clk;
  // ==========================================================================
  // Bus and compare tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(what, exp, rdat);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rchk("control reset", tmr2_pkg::ADDR_CONTROL, 32'h0000_0000);
    rchk("unmapped data", 8'h00, 32'h0000_0000);
    chk("unmapped resp", 32'(tmr2_pkg::RESP_SLVERR), 32'(rrsp));
    wr(8'h00, 32'h0000_0001);
  endtask
  task automatic t_overflow();
    logic [31:0] c0;
    wr(tmr2_pkg::ADDR_COUNT, 32'h0000_fff0);
    wr(tmr2_pkg::ADDR_CONTROL, 32'h0000_0004);
    repeat (30) @(posedge clk);
    rchk("overflow flag", tmr2_pkg::ADDR_CONTROL, 32'h0000_0084);
    rchk("status", tmr2_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    wr(tmr2_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq set", 32'h0000_0001, 32'(irq));
    wr(tmr2_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq clear", 32'h0000_0000, 32'(irq));
    wr(tmr2_pkg::ADDR_CONTROL, 32'h0000_0000);
    wr(tmr2_pkg::ADDR_COUNT, 32'h0000_5a5a);
    rchk("count a", tmr2_pkg::ADDR_COUNT, 32'h0000_5a5a);
    c0 = rdat;
    repeat (5) @(posedge clk);
    rchk("count stopped", tmr2_pkg::ADDR_COUNT, c0);
    // External counting: three falling edges on the count pin give three counts.
    wr(tmr2_pkg::ADDR_CONTROL, 32'h0000_0006);
    repeat (3) begin
      count_pin <= 1'h1;
      @(posedge clk);
      count_pin <= 1'h0;
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    wr(tmr2_pkg::ADDR_CONTROL, 32'h0000_0000);
    rchk("pin count", tmr2_pkg::ADDR_COUNT, 32'h0000_5a5d);
  endtask
  task automatic t_trigger();
    wr(tmr2_pkg::ADDR_RELOAD, 32'h0000_1234);
    wr(tmr2_pkg::ADDR_CONTROL, 32'h0000_0008);
    u_peer.fall();
    repeat (4) @(posedge clk);
    rchk("reload on edge", tmr2_pkg::ADDR_COUNT, 32'h0000_1234);
    rchk("event flag", tmr2_pkg::ADDR_CONTROL, 32'h0000_0048);
    timer2_int_enable <= 1'h1;
    repeat (3) @(posedge clk);
    chk("int request", 32'h0000_0001, 32'(timer2_int_request));
    wr(tmr2_pkg::ADDR_MODE, 32'h0000_0001);
    repeat (3) @(posedge clk);
    chk("int updown", 32'h0000_0000, 32'(timer2_int_request));
    wr(tmr2_pkg::ADDR_MODE, 32'h0000_0000);
    wr(tmr2_pkg::ADDR_CONTROL, 32'h0000_0009);
    wr(tmr2_pkg::ADDR_COUNT, 32'h0000_00a5);
    u_peer.fall();
    rchk("capture", tmr2_pkg::ADDR_RELOAD, 32'h0000_00a5);
    wr(tmr2_pkg::ADDR_CONTROL, 32'h0000_0000);
    timer2_int_enable <= 1'h0;
    u_peer.fall();
    rchk("edge ignored", tmr2_pkg::ADDR_CONTROL, 32'h0000_0000);
  endtask
  // Up/down mode: mode bit 1 picks the direction; the checks allow for bus latency.
  task automatic t_updown();
    logic [31:0] c0;
    wr(tmr2_pkg::ADDR_MODE, 32'h0000_0001);
    wr(tmr2_pkg::ADDR_COUNT, 32'h0000_0100);
    wr(tmr2_pkg::ADDR_CONTROL, 32'h0000_0004);
    repeat (8) @(posedge clk);
    wr(tmr2_pkg::ADDR_CONTROL, 32'h0000_0000);
    rd(tmr2_pkg::ADDR_COUNT);
    c0 = rdat;
    chk("count down", 32'h0000_0001, 32'(c0 < 32'h0000_0100 && c0 > 32'h0000_00e0));
    wr(tmr2_pkg::ADDR_MODE, 32'h0000_0003);
    wr(tmr2_pkg::ADDR_CONTROL, 32'h0000_0004);
    repeat (8) @(posedge clk);
    wr(tmr2_pkg::ADDR_CONTROL, 32'h0000_0000);
    rd(tmr2_pkg::ADDR_COUNT);
    chk("count up", 32'h0000_0001, 32'(rdat > c0 && rdat < 32'h0000_0120));
    wr(tmr2_pkg::ADDR_MODE, 32'h0000_0000);
  endtask
  // Timer 1 is held quiet so that every baud pulse seen must come from this timer.
  task automatic t_baud(input logic [31:0] ctl, input logic rx_on);
    serial_mode <= 2'h1;
    t1_on <= 1'h0;
    wr(tmr2_pkg::ADDR_RELOAD, 32'h0000_fff8);
    wr(tmr2_pkg::ADDR_COUNT, 32'h0000_fff8);
    wr(tmr2_pkg::ADDR_CONTROL, ctl);
    n0 = u_peer.rx_n;
    m0 = u_peer.tx_n;
    u_peer.fall();
    repeat (64) @(posedge clk);
    chk("rx pulses", 32'(rx_on), 32'(u_peer.rx_n > n0));
    chk("tx pulses", 32'(!rx_on), 32'(u_peer.tx_n > m0));
    rchk("baud flags", tmr2_pkg::ADDR_CONTROL, ctl);
    wr(tmr2_pkg::ADDR_CONTROL, 32'h0000_0000);
  endtask
  // ==========================================================================
  // Run control
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    t_reset();
    t_overflow();
    t_trigger();
    t_updown();
    t_baud(32'h0000_002c, 1'h1);
    t_baud(32'h0000_001c, 1'h0);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule

// [bench/tmr2_chk.sv]
`timescale 1ns/100ps
// ==========================================================================
// Bus and interrupt checker
module tmr2_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer
  input wire logic timer2_int_enable,
  input wire logic timer2_int_request
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_aw_ready_soon: assert property ($rose(s_axi_awvalid) |=> s_axi_awready)
    else $error("write address not taken a cycle after valid");
  a_ar_ready_soon: assert property ($rose(s_axi_arvalid) |=> s_axi_arready)
    else $error("read address not taken a cycle after valid");
  a_b_after_aw: assert property (s_axi_awready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_after_ar: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_unmapped_err: assert property (s_axi_awready && s_axi_awaddr == 8'h00
    |-> ##2 s_axi_bresp == tmr2_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  a_int_gate_en: assert property (!timer2_int_enable |=> !timer2_int_request)
    else $error("timer interrupt without enable");
  cover property (timer2_int_request);
  cover property (s_axi_bvalid && s_axi_bresp == tmr2_pkg::RESP_SLVERR);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind tmr2_control tmr2_chk u_chk (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .timer2_int_enable,
  .timer2_int_request);

// [bench/tmr2_peer.sv]
`timescale 1ns/100ps
// ==========================================================================
// Trigger pin, timer 1 and serial port side
module tmr2_peer (
  // Clock and control
  input wire logic clk,
  input wire logic t1_on,
  // Baud clocks seen
  input wire logic rx_baud_clock,
  input wire logic tx_baud_clock,
  // Driven pins
  output logic trigger_pin,
  output logic timer1_overflow
);
  int rx_n = 0;
  int tx_n = 0;
  logic [2:0] div = 3'h0;
  initial begin
    trigger_pin = 1'h1;
    timer1_overflow = 1'h0;
  end
  always @(posedge clk) begin
    div <= div + 3'h1;
    timer1_overflow <= t1_on && div == 3'h7;
    rx_n <= rx_n + int'(rx_baud_clock);
    tx_n <= tx_n + int'(tx_baud_clock);
  end
  // The pin has a pull-up, so it rests high between trigger events.
  task automatic fall();
    @(posedge clk);
    trigger_pin <= 1'h0;
    repeat (3) @(posedge clk);
    trigger_pin <= 1'h1;
  endtask
endmodule

// [verilog/tmr2_control.sv]
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Operation
// RL1: A falling trigger edge that captures or reloads, with trigger enable 1, sets the event flag.
// RL2: With the timer interrupt enabled a set event flag requests the interrupt until cleared.
// RL3: While up/down counting is enabled the event flag raises no interrupt.
// RL4: Receive baud select 1 routes this timer's overflows to the receiver, else timer 1's.
// RL5: Transmit baud select 1 routes this timer's overflows to the transmitter, else timer 1's.
// RL6: With trigger enable set a falling edge captures or reloads unless used as a baud clock.
// RL7: With trigger enable 0 every trigger pin transition is ignored.
// RL8: The timer counts only while run control is 1.
// RL9: With up/down enable set the timer counts up or down.
// RL10: Overflow sets the overflow flag except while a baud select bit is 1.
// RL11: Capture select 1 captures on an edge; 0 reloads on overflow or edge; baud forces reload.
module tmr2_control (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer inputs
  input wire logic trigger_pin,
  input wire logic count_pin,
  input wire logic timer1_overflow,
  input wire logic timer2_int_enable,
  input wire logic [1:0] serial_mode,
  // Outputs
  output logic rx_baud_clock,
  output logic tx_baud_clock,
  output logic timer2_int_request,
  output logic irq
);
  // ==========================================================================
  // State.
  logic [7:0] control;
  logic [1:0] mode;
  logic [15:0] count;
  logic [15:0] reload;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_have;
  logic w_have;
  tmr2_pkg::tmr2_bus_t wstate;
  tmr2_pkg::tmr2_bus_t rstate;
  // ==========================================================================
  // Timer datapath.
  wire trig_fall;
  wire src_fall;
  // Both detectors rest high after reset to match the trigger pin's pull-up.
  // A count pin held low gives no false count, as external counting is off after reset.
  tmr2_edge u_trig (
    .clk(clk),
    .reset(reset),
    .pin(trigger_pin),
    .fall(trig_fall)
  );
  tmr2_edge u_src (
    .clk(clk),
    .reset(reset),
    .pin(count_pin),
    .fall(src_fall)
  );
  wire baud_mode = control[tmr2_pkg::BIT_RXB] | control[tmr2_pkg::BIT_TXB];
  wire updown = mode[tmr2_pkg::BIT_UPDOWN];
  wire count_down = updown & ~mode[tmr2_pkg::BIT_DIR]; // [RL9]
  wire tick = control[tmr2_pkg::BIT_RUN] &
              (control[tmr2_pkg::BIT_SRC] ? src_fall : 1'b1); // [RL8]
  wire up_wrap = tick & ~count_down & (count == tmr2_pkg::COUNT_MAX);
  wire down_wrap = tick & count_down & (count == reload);
  wire wrap = up_wrap | down_wrap;
  // Edges are dropped entirely when trigger enable is 0 or the timer drives a baud clock.
  wire trig_event = trig_fall & control[tmr2_pkg::BIT_TRIG_EN] & ~baud_mode; // [RL6] [RL7]
  wire capture_mode = control[tmr2_pkg::BIT_CAP] & ~baud_mode; // [RL11]
  wire do_capture = trig_event & capture_mode;
  wire do_reload = ~capture_mode & (up_wrap | (trig_event & ~updown)); // [RL11]
  wire set_ovf = wrap & ~baud_mode; // [RL10]
  wire set_ext = do_capture | (trig_event & ~capture_mode & ~updown); // [RL1]
  // Down counting wraps to all ones when the count meets the reload value.
  wire [15:0] count_step = count_down ? count - 16'h0001 : count + 16'h0001;
  wire [15:0] next_count = do_reload ? reload :
                           down_wrap ? tmr2_pkg::COUNT_MAX :
                           tick ? count_step : count;
  // ==========================================================================
  // Bus decode.
  // A write acts only once both halves are held, whichever channel arrived first.
  wire wr_go = aw_have & w_have & (wstate == tmr2_pkg::TMR2_IDLE);
  wire wr_ctl = wr_go & (aw_addr == tmr2_pkg::ADDR_CONTROL) & w_strb[0];
  wire wr_mode = wr_go & (aw_addr == tmr2_pkg::ADDR_MODE) & w_strb[0];
  wire wr_cnt_lo = wr_go & (aw_addr == tmr2_pkg::ADDR_COUNT) & w_strb[0];
  wire wr_cnt_hi = wr_go & (aw_addr == tmr2_pkg::ADDR_COUNT) & w_strb[1];
  wire wr_rl_lo = wr_go & (aw_addr == tmr2_pkg::ADDR_RELOAD) & w_strb[0];
  wire wr_rl_hi = wr_go & (aw_addr == tmr2_pkg::ADDR_RELOAD) & w_strb[1];
  wire wr_ist = wr_go & (aw_addr == tmr2_pkg::ADDR_IRQ_STATUS) & w_strb[0];
  wire wr_imask = wr_go & (aw_addr == tmr2_pkg::ADDR_IRQ_MASK) & w_strb[0];
  // An unmapped address still completes, with an error response, so the master never hangs.
  wire wr_hit;
  assign wr_hit = (aw_addr == tmr2_pkg::ADDR_CONTROL) | (aw_addr == tmr2_pkg::ADDR_MODE) |
                  (aw_addr == tmr2_pkg::ADDR_COUNT) | (aw_addr == tmr2_pkg::ADDR_RELOAD) |
                  (aw_addr == tmr2_pkg::ADDR_IRQ_STATUS) | (aw_addr == tmr2_pkg::ADDR_IRQ_MASK);
  logic [31:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == tmr2_pkg::ADDR_CONTROL) begin
      rd_word = {24'h00_0000, control};
    end else if (s_axi_araddr == tmr2_pkg::ADDR_MODE) begin
      rd_word = {30'h0000_0000, mode};
    end else if (s_axi_araddr == tmr2_pkg::ADDR_COUNT) begin
      rd_word = {16'h0000, count};
    end else if (s_axi_araddr == tmr2_pkg::ADDR_RELOAD) begin
      rd_word = {16'h0000, reload};
    end else if (s_axi_araddr == tmr2_pkg::ADDR_IRQ_STATUS) begin
      rd_word = {30'h0000_0000, irq_status};
    end else if (s_axi_araddr == tmr2_pkg::ADDR_IRQ_MASK) begin
      rd_word = {30'h0000_0000, irq_mask};
    end else begin
      rd_hit = 1'b0;
    end
  end
  // A flag write of 0 clears, but a hardware set in the same cycle wins.
  wire [7:0] ctl_wr = wr_ctl ? w_data[7:0] : control;
  wire [7:0] next_control = {ctl_wr[7] | set_ovf, ctl_wr[6] | set_ext, ctl_wr[5:0]}; // [RL10]
  wire [1:0] ist_clr = wr_ist ? w_data[1:0] : 2'b00;
  wire [1:0] next_irq_status = (irq_status & ~ist_clr) | {set_ext, set_ovf};
  wire ext_int = control[tmr2_pkg::BIT_EXT] & ~updown; // [RL3]
  wire next_t2_req = timer2_int_enable & (control[tmr2_pkg::BIT_OVF] | ext_int); // [RL2]
  wire var_mode = serial_mode[0]; // Modes 1 and 3 use a variable baud clock.
  // Timer 1 overflows pass straight through when this timer is not selected.
  wire next_rx_baud = var_mode &
                      (control[tmr2_pkg::BIT_RXB] ? wrap : timer1_overflow); // [RL4]
  wire next_tx_baud = var_mode &
                      (control[tmr2_pkg::BIT_TXB] ? wrap : timer1_overflow); // [RL5]
  wire next_irq = |(irq_status & irq_mask);
  // ==========================================================================
  // Control and status flags.
  // Flags and status bits update every clock, since hardware may set them at any time.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      control <= tmr2_pkg::CONTROL_RESET;
      irq_status <= 2'b00;
    end else begin
      control <= next_control; // [RL1]
      irq_status <= next_irq_status;
    end
  end
  // ==========================================================================
  // Mode and interrupt mask.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode <= 2'b00;
    end else if (wr_mode) begin
      mode <= w_data[1:0];
    end
  end
  // The mask only gates the irq output; the status bits keep recording events.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_mask <= 2'b00;
    end else if (wr_imask) begin
      irq_mask <= w_data[1:0];
    end
  end
  // ==========================================================================
  // Reload and capture register.
  // One register serves both purposes, so a capture overwrites the reload value; software
  // that returns from capture to auto-reload must write the reload value again first.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reload <= tmr2_pkg::COUNT_RESET;
    end else begin
      if (wr_rl_lo) begin
        reload[7:0] <= w_data[7:0];
      end
      if (wr_rl_hi) begin
        reload[15:8] <= w_data[15:8];
      end else if (do_capture) begin
        reload <= count; // [RL11]
      end
    end
  end
  // ==========================================================================
  // Registered outputs.
  // Every output leaves through a flip-flop, so requests and baud pulses trail their cause
  // by one clock; the serial port sees the same latency from either baud source.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer2_int_request <= 1'b0;
      rx_baud_clock <= 1'b0;
      tx_baud_clock <= 1'b0;
      irq <= 1'b0;
    end else begin
      timer2_int_request <= next_t2_req;
      rx_baud_clock <= next_rx_baud;
      tx_baud_clock <= next_tx_baud;
      irq <= next_irq;
    end
  end
  // Software count writes take priority over the timer.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= tmr2_pkg::COUNT_RESET;
    end else begin
      count[7:0] <= wr_cnt_lo ? w_data[7:0] : next_count[7:0];
      count[15:8] <= wr_cnt_hi ? w_data[15:8] : next_count[15:8];
    end
  end
  // ==========================================================================
  // AXI4-Lite write channel.
  // Each ready is a one-cycle pulse, so a valid held one cycle too long is not taken twice.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tmr2_pkg::RESP_OKAY;
      wstate <= tmr2_pkg::TMR2_IDLE;
    end else begin
      s_axi_awready <= ~aw_have & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_have & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      case (wstate)
        tmr2_pkg::TMR2_IDLE: begin
          if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? tmr2_pkg::RESP_OKAY : tmr2_pkg::RESP_SLVERR;
            wstate <= tmr2_pkg::TMR2_RESP;
          end
        end
        default: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            wstate <= tmr2_pkg::TMR2_IDLE;
          end
        end
      endcase
    end
  end
  // ==========================================================================
  // AXI4-Lite read channel.
  // The read word is latched at the address handshake, so a count read is a snapshot.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tmr2_pkg::RESP_OKAY;
      rstate <= tmr2_pkg::TMR2_IDLE;
    end else begin
      case (rstate)
        tmr2_pkg::TMR2_IDLE: begin
          s_axi_arready <= s_axi_arvalid & ~s_axi_arready;
          if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? tmr2_pkg::RESP_OKAY : tmr2_pkg::RESP_SLVERR;
            rstate <= tmr2_pkg::TMR2_RESP;
          end
        end
        default: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rstate <= tmr2_pkg::TMR2_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// [verilog/tmr2_edge.sv]
`timescale 1ns/100ps
// Falling-edge detector on a pin that is already synchronous to clk.
module tmr2_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pin and event
  input wire logic pin,
  output logic fall
);
  logic last;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last <= 1'b1;
    end else begin
      last <= pin;
    end
  end
  assign fall = last & ~pin;
endmodule

// [verilog/tmr2_pkg.sv]
package tmr2_pkg;
  // ==========================================================================
  // Register map (byte addresses on the AXI4-Lite slave).
  localparam logic [7:0] ADDR_CONTROL = 8'hc8;
  localparam logic [7:0] ADDR_MODE = 8'hcc;
  localparam logic [7:0] ADDR_COUNT = 8'hd0;
  localparam logic [7:0] ADDR_RELOAD = 8'hd4;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'hd8;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hdc;
  // ==========================================================================
  // Control and mode register field positions (BIT_UPDOWN and BIT_DIR are in the mode register).
  localparam int BIT_OVF = 7;
  localparam int BIT_EXT = 6;
  localparam int BIT_RXB = 5;
  localparam int BIT_TXB = 4;
  localparam int BIT_TRIG_EN = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_SRC = 1;
  localparam int BIT_CAP = 0;
  localparam int BIT_UPDOWN = 0;
  localparam int BIT_DIR = 1;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  // ==========================================================================
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Interrupt status bit positions: 0 overflow, 1 external event.
  localparam int IRQ_OVF = 0;
  localparam int IRQ_EXT = 1;
  typedef enum logic [1:0] {
    TMR2_IDLE = 2'b00,
    TMR2_RESP = 2'b01
  } tmr2_bus_t;
endpackage
